// file: rtl/cfog_gate.sv
/*
  reference clock side: takes the enable word over a toggle handshake
  and gates each output with an enable that changes only while the
  reference clock is low.
  assumes: the word is held stable for several reference cycles after
  each toggle; buf_in runs whenever enables are to change.
*/
`include "cfog_defs.svh"

module cfog_gate
  import cfog_pkg::*;
(
  // reference clock and reset
  input  wire logic        buf_in,
  input  wire logic        rst_n,
  // enable hand-off from the system clock side
  input  cfog_pkg::cfog_xfer_t xfer,
  // gated clocks
  output cfog_pkg::cfog_en_t   clk_out
);
  import cfog_pkg::*;

  logic     tgl_s1_r, tgl_s1_nxt;
  logic     tgl_s2_r, tgl_s2_nxt;
  logic     tgl_d_r,  tgl_d_nxt;
  cfog_en_t cap_r,    cap_nxt;
  cfog_en_t en_r,     en_nxt;

  // ----------------------------------------------------------------------
  // toggle synchroniser and word capture
  // ----------------------------------------------------------------------
  always_comb begin
    tgl_s1_nxt = xfer.tgl;
    tgl_s2_nxt = tgl_s1_r;
    tgl_d_nxt  = tgl_s2_r;
    // word is stable here: it settled long before the toggle arrived
    cap_nxt    = (tgl_s2_r ^ tgl_d_r) ? xfer.word : cap_r;
  end

  always_ff @(posedge buf_in or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_d_r  <= 1'b0;
      cap_r    <= `CFOG_EN_RST;
    end else begin
      tgl_s1_r <= tgl_s1_nxt;
      tgl_s2_r <= tgl_s2_nxt;
      tgl_d_r  <= tgl_d_nxt;
      cap_r    <= cap_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // low-phase enable and gating
  // ----------------------------------------------------------------------
  // updating on the falling edge keeps the and-gate free of runt pulses
  always_comb begin
    en_nxt = cap_r;
  end

  always_ff @(negedge buf_in or negedge rst_n) begin
    if (!rst_n) begin
      en_r <= `CFOG_EN_RST;
    end else begin
      en_r <= en_nxt;
    end
  end

  assign clk_out = {`CFOG_NOUT{buf_in}} & en_r;

  a_gate_capture: assert property (
    @(posedge buf_in) disable iff (!rst_n)
    (tgl_s2_r != tgl_d_r) |=> (cap_r == $past(xfer.word)))
    else $error("enable word not captured after toggle");

  a_gate_track: assert property (
    @(posedge buf_in) disable iff (!rst_n)
    en_r == cap_r)
    else $error("gate enable lags captured word at rising edge");

  genvar gi;
  generate
    for (gi = 0; gi < `CFOG_NOUT; gi++) begin : g_off
      a_gate_off_low: assert property (
        @(negedge buf_in) disable iff (!rst_n)
        !en_r[gi] |-> !clk_out[gi])
        else $error("disabled output pulsed high");
    end
  endgenerate

endmodule // cfog_gate

// file: rtl/cfog_top.sv
/*
  clock fan-out gating block: two-wire serial write slave holding three
  enable bytes, output-enable pin handling, and the hand-off of the ten
  enables to the gating stage on the reference clock.
  assumes: serial clock, serial data and the enable pin are asynchronous
  to clk and slow against it (serial clock well under clk / 8).
*/
`include "cfog_defs.svh"

// Behaviour
// - pin low floats every output; pin high repeats the reference clock on each enabled output.
// - after reset every clock output is enabled before any serial write.
// - bytes go in order from byte zero, each most significant bit first.
// - only address 1101001 with a write direction bit is acknowledged.
// - byte zero bits 3 to 0 enable memory clocks 3 to 0.
// - byte one bits 7 to 4 enable memory clocks 7 to 4.
// - byte two bits 7 and 6 enable feedback clocks 9 and 8.
module cfog_top
  import cfog_pkg::*;
(
  // system clock, reset, freeze
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // reference clock and output enable pin
  input  wire logic        buf_in,
  input  wire logic        oe_pin,
  // two-wire serial port, data line open drain
  input  wire logic        serial_clock,
  input  wire logic        serial_data_line_i,
  output logic             serial_data_line_o,
  output logic             serial_data_line_oe,
  // clock outputs and their common drive enable
  output cfog_pkg::cfog_en_t clk_out,
  output logic             clk_out_oe
);
  import cfog_pkg::*;

  // pin synchronisers
  logic        scl_s1_r, scl_s1_nxt, scl_s2_r, scl_s2_nxt;
  logic        scl_d_r,  scl_d_nxt;
  logic        sda_s1_r, sda_s1_nxt, sda_s2_r, sda_s2_nxt;
  logic        sda_d_r,  sda_d_nxt;
  logic        oe_s1_r,  oe_s1_nxt,  oe_s2_r,  oe_s2_nxt;
  // serial protocol
  cfog_state_t state_r,  state_nxt;
  logic [2:0]  cnt_r,    cnt_nxt;
  logic        full_r,   full_nxt;
  logic [7:0]  shift_r,  shift_nxt;
  logic [1:0]  idx_r,    idx_nxt;
  logic        sda_oe_r, sda_oe_nxt;
  logic        wr_fire;
  // configuration and hand-off
  cfog_cfg_t   cfg_r,    cfg_nxt;
  cfog_en_t    word_r,   word_nxt;
  logic        tgl_r,    tgl_nxt;
  logic        out_oe_r, out_oe_nxt;
  logic        wrote_r,  wrote_nxt;
  cfog_xfer_t  xfer;
  // bus events
  logic        start_ev, stop_ev, scl_rise, scl_fall;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  // the delayed copies feed edge detection; first stages go nowhere else
  always_comb begin
    scl_s1_nxt = serial_clock;
    scl_s2_nxt = scl_s1_r;
    scl_d_nxt  = scl_s2_r;
    sda_s1_nxt = serial_data_line_i;
    sda_s2_nxt = sda_s1_r;
    sda_d_nxt  = sda_s2_r;
    oe_s1_nxt  = oe_pin;
    oe_s2_nxt  = oe_s1_r;
  end

  // lines idle high, so reset to high avoids a false start
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_d_r  <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_d_r  <= 1'b1;
      oe_s1_r  <= 1'b0;
      oe_s2_r  <= 1'b0;
    end else if (ce) begin
      scl_s1_r <= scl_s1_nxt;
      scl_s2_r <= scl_s2_nxt;
      scl_d_r  <= scl_d_nxt;
      sda_s1_r <= sda_s1_nxt;
      sda_s2_r <= sda_s2_nxt;
      sda_d_r  <= sda_d_nxt;
      oe_s1_r  <= oe_s1_nxt;
      oe_s2_r  <= oe_s2_nxt;
    end
  end

  // start and stop are data edges while the serial clock stays high
  assign start_ev = ce & scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  assign stop_ev  = ce & scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  assign scl_rise = ce & scl_s2_r & ~scl_d_r;
  assign scl_fall = ce & ~scl_s2_r & scl_d_r;

  // ----------------------------------------------------------------------
  // serial write slave
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    full_nxt   = full_r;
    shift_nxt  = shift_r;
    idx_nxt    = idx_r;
    sda_oe_nxt = sda_oe_r;
    wr_fire    = 1'b0;
    if (start_ev) begin
      // a repeated start begins again at byte zero
      state_nxt  = CFOG_ADDR;
      cnt_nxt    = `CFOG_CNT_ZERO;
      full_nxt   = 1'b0;
      idx_nxt    = `CFOG_IDX_LOW;
      sda_oe_nxt = 1'b0;
    end else if (stop_ev) begin
      state_nxt  = CFOG_IDLE;
      full_nxt   = 1'b0;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        CFOG_IDLE, CFOG_IGNORE: begin
          sda_oe_nxt = 1'b0;
        end
        CFOG_ADDR, CFOG_DATA: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_s2_r};
            cnt_nxt   = cnt_r + `CFOG_CNT_ONE;
            full_nxt  = (cnt_r == `CFOG_BIT_LAST);
          end else if (scl_fall && full_r) begin
            full_nxt = 1'b0;
            if (state_r == CFOG_ADDR) begin
              if (shift_r == {`CFOG_DEV_ADDR, `CFOG_DIR_WRITE}) begin
                state_nxt  = CFOG_ACK;
                sda_oe_nxt = 1'b1;
              end else begin
                state_nxt  = CFOG_IGNORE;
              end
            end else if (idx_r != `CFOG_NBYTES) begin
              wr_fire    = 1'b1;
              idx_nxt    = idx_r + `CFOG_IDX_ONE;
              state_nxt  = CFOG_ACK;
              sda_oe_nxt = 1'b1;
            end else begin
              // bytes past the last one are refused with no acknowledge
              state_nxt  = CFOG_IGNORE;
            end
          end
        end
        CFOG_ACK: begin
          if (scl_fall) begin
            state_nxt  = CFOG_DATA;
            sda_oe_nxt = 1'b0;
          end
        end
        default: begin
          state_nxt  = CFOG_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= CFOG_IDLE;
      cnt_r    <= `CFOG_CNT_ZERO;
      full_r   <= 1'b0;
      shift_r  <= 8'h00;
      idx_r    <= `CFOG_IDX_LOW;
      sda_oe_r <= 1'b0;
    end else if (ce) begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      full_r   <= full_nxt;
      shift_r  <= shift_nxt;
      idx_r    <= idx_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  assign serial_data_line_o  = 1'b0; // open drain: only ever pulls low
  assign serial_data_line_oe = sda_oe_r;

  // ----------------------------------------------------------------------
  // configuration bytes and hand-off to the reference clock
  // ----------------------------------------------------------------------
  // word follows the bytes in the same cycle, so it is settled before
  // the toggle can be seen on the far side
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_fire) begin
      unique case (idx_r)
        `CFOG_IDX_LOW: cfg_nxt.low = shift_r;
        `CFOG_IDX_MID: cfg_nxt.mid = shift_r;
        default:       cfg_nxt.fb  = shift_r;
      endcase
    end
    word_nxt   = cfog_map(cfg_nxt);
    tgl_nxt    = tgl_r ^ wr_fire;
    out_oe_nxt = oe_s2_r;
    wrote_nxt  = wrote_r | wr_fire;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r    <= '{low: `CFOG_LOW_RST, mid: `CFOG_MID_RST,
                    fb: `CFOG_FB_RST};
      word_r   <= `CFOG_EN_RST;
      tgl_r    <= 1'b0;
      out_oe_r <= 1'b0;
      wrote_r  <= 1'b0;
    end else if (ce) begin
      cfg_r    <= cfg_nxt;
      word_r   <= word_nxt;
      tgl_r    <= tgl_nxt;
      out_oe_r <= out_oe_nxt;
      wrote_r  <= wrote_nxt;
    end
  end

  assign clk_out_oe = out_oe_r;
  assign xfer       = '{tgl: tgl_r, word: word_r};

  // ----------------------------------------------------------------------
  // gating stage on the reference clock
  // ----------------------------------------------------------------------
  cfog_gate u_gate (
    .buf_in  (buf_in),
    .rst_n   (rst_n),
    .xfer    (xfer),
    .clk_out (clk_out)
  );

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_oe_follow: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce ##1 ce |-> clk_out_oe == $past(oe_s2_r))
    else $error("output drive enable does not follow the pin");

  a_reset_all_on: assert property (
    @(posedge clk) disable iff (!rst_n)
    !wrote_r |-> word_r == `CFOG_EN_RST)
    else $error("outputs not all enabled before first write");

  a_first_byte: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_fire && idx_r == `CFOG_IDX_LOW |=> cfg_r.low == $past(shift_r))
    else $error("first data byte not stored in byte zero");

  a_msb_first: assert property (
    @(posedge clk) disable iff (!rst_n)
    scl_rise && (state_r == CFOG_DATA) && !start_ev && !stop_ev |=>
      shift_r == {$past(shift_r[6:0]), $past(sda_s2_r)})
    else $error("serial bits not shifted in msb first");

  a_addr_ack: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_r == CFOG_ADDR && scl_fall && full_r && !start_ev && !stop_ev
      && shift_r == {`CFOG_DEV_ADDR, `CFOG_DIR_WRITE}
      |=> sda_oe_r && state_r == CFOG_ACK)
    else $error("own address not acknowledged");

  a_addr_nack: assert property (
    @(posedge clk) disable iff (!rst_n)
    state_r == CFOG_ADDR && scl_fall && full_r && !start_ev && !stop_ev
      && shift_r != {`CFOG_DEV_ADDR, `CFOG_DIR_WRITE}
      |=> !sda_oe_r && state_r == CFOG_IGNORE)
    else $error("foreign address acknowledged");

  a_low_map: assert property (
    @(posedge clk) disable iff (!rst_n)
    word_r[`CFOG_W_LOW] == cfg_r.low[`CFOG_LOW_FLD])
    else $error("byte zero enables mismatch");

  a_mid_map: assert property (
    @(posedge clk) disable iff (!rst_n)
    word_r[`CFOG_W_MID] == cfg_r.mid[`CFOG_MID_FLD])
    else $error("byte one enables mismatch");

  a_fb_map: assert property (
    @(posedge clk) disable iff (!rst_n)
    word_r[`CFOG_W_FB] == cfg_r.fb[`CFOG_FB_FLD])
    else $error("byte two enables mismatch");

  a_write_toggle: assert property (
    @(posedge clk) disable iff (!rst_n)
    wr_fire && ce |=> tgl_r != $past(tgl_r))
    else $error("write did not toggle the hand-off");

endmodule // cfog_top

// file: shared/cfog_defs.svh
/*
  constants of the clock fan-out gating block: serial address, byte
  indices, reset values and field positions.
  assumes: included by its bare name, before the package and the modules.
*/
`ifndef CFOG_DEFS_SVH
`define CFOG_DEFS_SVH

// ----------------------------------------------------------------------
// sizes and serial address
// ----------------------------------------------------------------------
`define CFOG_NOUT      10
`define CFOG_DEV_ADDR  7'h69
`define CFOG_DIR_WRITE 1'h0
`define CFOG_BIT_LAST  3'h7
`define CFOG_CNT_ZERO  3'h0
`define CFOG_CNT_ONE   3'h1

// ----------------------------------------------------------------------
// configuration bytes: index, reset value, enable fields
// ----------------------------------------------------------------------
`define CFOG_NBYTES    2'h3
`define CFOG_IDX_LOW   2'h0
`define CFOG_IDX_MID   2'h1
`define CFOG_IDX_ONE   2'h1
`define CFOG_LOW_RST   8'h0F
`define CFOG_MID_RST   8'hF0
`define CFOG_FB_RST    8'hC0
`define CFOG_EN_RST    10'h03FF
`define CFOG_LOW_FLD   3:0
`define CFOG_MID_FLD   7:4
`define CFOG_FB_FLD    7:6
`define CFOG_W_LOW     3:0
`define CFOG_W_MID     7:4
`define CFOG_W_FB      9:8

`endif

// file: shared/cfog_pkg.sv
/*
  types of the clock fan-out gating block: serial states, the
  configuration bytes, the enable word and its hand-off carrier.
  assumes: cfog_defs.svh is on the include path.
*/
`include "cfog_defs.svh"

package cfog_pkg;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef logic [`CFOG_NOUT-1:0] cfog_en_t;

  typedef enum logic [2:0] {
    CFOG_IDLE   = 3'h0,
    CFOG_ADDR   = 3'h1,
    CFOG_ACK    = 3'h2,
    CFOG_DATA   = 3'h3,
    CFOG_IGNORE = 3'h4
  } cfog_state_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] mid;
    logic [7:0] fb;
  } cfog_cfg_t;

  typedef struct packed {
    logic     tgl;
    cfog_en_t word;
  } cfog_xfer_t;

  // pick the ten enable bits out of the three bytes
  function automatic cfog_en_t cfog_map(input cfog_cfg_t c);
    cfog_en_t w;
    w[`CFOG_W_LOW] = c.low[`CFOG_LOW_FLD];
    w[`CFOG_W_MID] = c.mid[`CFOG_MID_FLD];
    w[`CFOG_W_FB]  = c.fb[`CFOG_FB_FLD];
    return w;
  endfunction

endpackage

// file: tb/cfog_ctl_model.sv
/*
  serial bus controller model: writes enable bytes to the fan-out block
  over the two-wire port, msb first, and samples the ninth-bit answer.
  assumes: the data line has a pull-up outside this model and the model
  only ever pulls it low; bit timing is paced by the system clock.
*/
module cfog_ctl_model (
  // pacing clock
  input  wire logic clk,
  // two-wire pins: clock driven, data only pulled low
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------------
  // serial clock high phase in clk cycles, a third of a bit period, twice the shortest the block allows
  localparam int HALF = 8;

  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // changes land on falling clk edges, away from the sampling edge
  task automatic gap();
    repeat (HALF) @(negedge clk);
  endtask

  // ----------------------------------------------------------------------
  // frame pieces
  // ----------------------------------------------------------------------
  // start or repeated start: data falls while the clock is high
  task automatic start();
    sda_low = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b1;
    gap();
    scl = 1'b0;
    gap();
  endtask

  // one byte, then a ninth pulse with the line released
  task automatic send_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_low = ~b[i];
      gap();
      scl = 1'b1;
      gap();
      scl = 1'b0;
      gap();
    end
    sda_low = 1'b0;
    gap();
    scl = 1'b1;
    gap();
    ack = ~sda;
    scl = 1'b0;
    gap();
  endtask

  // stop: data rises while the clock is high
  task automatic stop();
    sda_low = 1'b1;
    gap();
    scl = 1'b1;
    gap();
    sda_low = 1'b0;
    gap();
  endtask

endmodule // cfog_ctl_model

// file: tb/tb_clock_fanout_output_gating.sv
/*
  self-checking bench of the clock fan-out gating block: random and
  corner enable writes, refused addresses, partial writes, enable pin.
  assumes: cfog_defs.svh on the include path; clk 50 ns, reference 15 ns.
*/
`include "cfog_defs.svh"

module tb_clock_fanout_output_gating;
  import cfog_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------------
  logic      clk;
  logic      rst_n;
  logic      ce;
  logic      buf_in;
  logic      oe_pin;
  logic      scl;
  logic      sda_low;
  logic      sdo;
  logic      sdo_oe;
  logic      clk_out_oe;
  cfog_en_t  clk_out;
  wire logic sda_wire;
  int        err_count = 0;
  int        total_checks = 0;
  integer    seed = 32'h451f;

  // pull-up wins unless someone pulls low
  assign sda_wire = ~(sda_low | (sdo_oe & ~sdo));

  always #25 clk = ~clk;
  // reference clock, free running and unrelated in phase to clk
  always #7.5 buf_in = ~buf_in;

  cfog_top dut (
    .clk                 (clk),
    .rst_n               (rst_n),
    .ce                  (ce),
    .buf_in              (buf_in),
    .oe_pin              (oe_pin),
    .serial_clock        (scl),
    .serial_data_line_i  (sda_wire),
    .serial_data_line_o  (sdo),
    .serial_data_line_oe (sdo_oe),
    .clk_out             (clk_out),
    .clk_out_oe          (clk_out_oe)
  );

  cfog_ctl_model ctl (
    .clk     (clk),
    .scl     (scl),
    .sda_low (sda_low),
    .sda     (sda_wire)
  );

  // ----------------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // output order: feedback 9..8, then memory clocks 7..0
  function automatic cfog_en_t exp_en(input logic [7:0] b0, b1, b2);
    return {b2[7], b2[6], b1[7:4], b0[3:0]};
  endfunction

  // enabled outputs follow the reference high, all sit low otherwise
  task automatic chk_out(input cfog_en_t e);
    @(posedge buf_in);
    #1;
    chk("outputs high phase", {6'h00, e}, {6'h00, clk_out});
    @(negedge buf_in);
    #1;
    chk("outputs low phase", 16'h0000, {6'h00, clk_out});
  endtask

  // one frame: address byte then n data bytes, ack bits returned
  task automatic wr(input logic [7:0] a, input logic [7:0] b0, b1, b2,
                    input int n, output logic [3:0] ak);
    logic [7:0] d [3];
    d = '{b0, b1, b2};
    ak = 4'h0;
    ctl.start();
    ctl.send_byte(a, ak[0]);
    for (int i = 0; i < n; i++) begin
      ctl.send_byte(d[i], ak[i+1]);
    end
    ctl.stop();
    repeat (10) @(negedge clk);
  endtask

  // an enable change inside a high phase would cut a pulse short
  always @(posedge buf_in) begin : hi_chk
    cfog_en_t v;
    #1;
    v = clk_out;
    #5;
    if (rst_n === 1'b1) begin
      chk("high phase steady", {6'h00, v}, {6'h00, clk_out});
    end
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // writes take about 50 us each; a millisecond is ample
  initial begin
    #1_000_000;
    err_count++;
    $display("Error watchdog expected finish seen hang");
    end_sim();
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0]  a;
    logic [7:0]  b0;
    logic [7:0]  b1;
    logic [7:0]  b2;
    logic [31:0] r;
    logic [3:0]  ak;
    cfog_en_t    cur;
    clk    = 1'b0;
    buf_in = 1'b0;
    rst_n  = 1'b0;
    ce     = 1'b1;
    oe_pin = 1'b1;
    a      = {`CFOG_DEV_ADDR, `CFOG_DIR_WRITE};
    repeat (4) @(negedge clk);
    chk("drive in reset", 16'h0000, {15'h0, clk_out_oe});
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    chk("drive after reset", 16'h0001, {15'h0, clk_out_oe});
    chk_out(`CFOG_EN_RST);
    // full writes: all off, all on, then random; reserved bits zero
    for (int i = 0; i < 6; i++) begin
      r = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'hFFFF_FFFF : $random(seed);
      b0 = {4'h0, r[3:0]};
      b1 = {r[7:4], 4'h0};
      b2 = {r[9:8], 6'h00};
      wr(a, b0, b1, b2, 3, ak);
      chk("ack full write", 16'h000F, {12'h000, ak});
      cur = exp_en(b0, b1, b2);
      chk_out(cur);
    end
    // one byte only lands in byte zero
    r = $random(seed);
    b0 = {4'h0, ~cur[3:0]};
    wr(a, b0, r[7:0], r[15:8], 1, ak);
    chk("ack short write", 16'h0003, {12'h000, ak});
    cur[3:0] = b0[3:0];
    chk_out(cur);
    // a neighbour address and the read direction are both ignored
    for (int i = 0; i < 2; i++) begin
      b0 = (i == 0) ? {`CFOG_DEV_ADDR ^ 7'h01, 1'b0} : {`CFOG_DEV_ADDR, 1'b1};
      wr(b0, 8'h00, 8'h00, 8'h00, 3, ak);
      chk("ack refused", 16'h0000, {12'h000, ak});
      chk_out(cur);
    end
    // reset in mid-run drops the drive and enables every output again
    @(negedge clk);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    chk("drive in mid reset", 16'h0000, {15'h0, clk_out_oe});
    rst_n = 1'b1;
    repeat (6) @(negedge clk);
    cur = `CFOG_EN_RST;
    chk_out(cur);
    // ce low freezes the pin path, so the drive holds its old state
    @(negedge clk);
    ce = 1'b0;
    oe_pin = 1'b0;
    repeat (5) @(negedge clk);
    chk("drive frozen", 16'h0001, {15'h0, clk_out_oe});
    // enable pin low floats every output, high drives again
    ce = 1'b1;
    repeat (5) @(negedge clk);
    chk("drive pin low", 16'h0000, {15'h0, clk_out_oe});
    oe_pin = 1'b1;
    repeat (5) @(negedge clk);
    chk("drive pin high", 16'h0001, {15'h0, clk_out_oe});
    chk_out(cur);
    end_sim();
  end

endmodule // tb_clock_fanout_output_gating
